// file: core/branch_skip_pkg.sv
package branch_skip_pkg;

  // ****************************************
  // Opcode patterns and masks
  // ****************************************
  localparam logic [15:0] MASK_OP6 = 16'hfc00;
  localparam logic [15:0] MASK_OP4 = 16'hf000;
  localparam logic [15:0] MASK_REGSKIP = 16'hfe08;
  localparam logic [15:0] MASK_IOSKIP = 16'hff00;
  localparam logic [15:0] OPC_CMP_SKIP_EQ = 16'h1000;
  localparam logic [15:0] OPC_CMP_REGS = 16'h1400;
  localparam logic [15:0] OPC_CMP_CARRY = 16'h0400;
  localparam logic [15:0] OPC_CMP_IMM = 16'h3000;
  localparam logic [15:0] OPC_SKIP_REG_CLR = 16'hfc00;
  localparam logic [15:0] OPC_SKIP_REG_SET = 16'hfe00;
  localparam logic [15:0] OPC_SKIP_IO_CLR = 16'h9900;
  localparam logic [15:0] OPC_SKIP_IO_SET = 16'h9b00;
  localparam logic [15:0] OPC_BRANCH_SET = 16'hf000;
  localparam logic [15:0] OPC_BRANCH_CLR = 16'hf400;

  // ****************************************
  // Flag positions in flag_register
  // ****************************************
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;

  // ****************************************
  // Program counter steps and cycle counts
  // ****************************************
  localparam logic [15:0] PC_STEP_NEXT = 16'h0001;
  localparam logic [15:0] PC_SKIP_SHORT = 16'h0002;
  localparam logic [15:0] PC_SKIP_LONG = 16'h0003;
  localparam int unsigned CYC_PLAIN = 1;
  localparam int unsigned CYC_BRANCH_TAKEN = 2;
  localparam int unsigned CYC_SKIP_SHORT = 2;
  localparam int unsigned CYC_SKIP_LONG = 3;
  localparam logic [15:0] RESET_PC_NEXT = 16'h0000;
  localparam logic [7:0] RESET_FLAGS = 8'h00;

  typedef enum logic [1:0]
  {
    ST_READY = 2'b00,
    ST_LAST = 2'b01,
    ST_FIRST = 2'b11
  } seq_state_t;

endpackage

// file: core/compare_flags.sv
`timescale 1ns/1ps
`default_nettype none
module compare_flags
  import branch_skip_pkg::*;
(
  input wire logic [7:0] minuend,
  input wire logic [7:0] subtrahend,
  input wire logic useCarry,
  input wire logic [7:0] flagsIn,
  output logic [7:0] flagsNew
);
  logic [7:0] diff;
  logic ovf;
  logic neg;

  always_comb
  begin
    diff = minuend - subtrahend - {7'h00, useCarry & flagsIn[FLAG_C]};
    neg = diff[7];
    ovf = (minuend[7] & ~subtrahend[7] & ~diff[7]) | (~minuend[7] & subtrahend[7] & diff[7]);
    flagsNew = flagsIn;
    // Chained compare keeps zero only if earlier bytes were equal too
    flagsNew[FLAG_Z] = (diff == 8'h00) & (~useCarry | flagsIn[FLAG_Z]);
    flagsNew[FLAG_N] = neg;
    flagsNew[FLAG_V] = ovf;
    flagsNew[FLAG_S] = neg ^ ovf;
    flagsNew[FLAG_C] = (~minuend[7] & subtrahend[7]) | (subtrahend[7] & diff[7])
      | (diff[7] & ~minuend[7]);
    flagsNew[FLAG_H] = (~minuend[3] & subtrahend[3]) | (subtrahend[3] & diff[3])
      | (diff[3] & ~minuend[3]);
  end
endmodule
`default_nettype wire

// file: core/branch_compare_skip_unit.sv
`timescale 1ns/1ps
`default_nettype none
module branch_compare_skip_unit
  import branch_skip_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic instrValid,
  input wire logic [15:0] instr,
  input wire logic [15:0] pc,
  input wire logic nextIsTwoWord,
  input wire logic [7:0] regD,
  input wire logic [7:0] regR,
  input wire logic [7:0] ioByte,
  input wire logic [7:0] flagsIn,
  output logic [4:0] regDAddr,
  output logic [4:0] regRAddr,
  output logic [4:0] ioAddr,
  output logic decodeHit,
  output logic instrReady,
  output logic pcLoad,
  output logic [15:0] pcNext,
  output logic flagWrite,
  output logic [7:0] flagsOut
);

  // ****************************************
  // Decode
  // ****************************************
  logic isEqSkip, isCmpRegs, isCmpCarry, isCmpImm, isCmp;
  logic isRegClr, isRegSet, isIoClr, isIoSet, isFlagSet, isFlagClr, isBranch;
  logic regBit, ioBit, flagBit, taken, skip, accept;
  logic [7:0] cmpOperand;
  logic [7:0] cmpFlags;
  logic [15:0] offset;
  logic [15:0] target;
  logic [1:0] holds;

  always_comb
  begin
    isEqSkip = (instr & MASK_OP6) == OPC_CMP_SKIP_EQ;
    isCmpRegs = (instr & MASK_OP6) == OPC_CMP_REGS;
    isCmpCarry = (instr & MASK_OP6) == OPC_CMP_CARRY;
    isCmpImm = (instr & MASK_OP4) == OPC_CMP_IMM;
    isCmp = isCmpRegs | isCmpCarry | isCmpImm;
    isRegClr = (instr & MASK_REGSKIP) == OPC_SKIP_REG_CLR;
    isRegSet = (instr & MASK_REGSKIP) == OPC_SKIP_REG_SET;
    isIoClr = (instr & MASK_IOSKIP) == OPC_SKIP_IO_CLR;
    isIoSet = (instr & MASK_IOSKIP) == OPC_SKIP_IO_SET;
    isFlagSet = (instr & MASK_OP6) == OPC_BRANCH_SET;
    isFlagClr = (instr & MASK_OP6) == OPC_BRANCH_CLR;
    isBranch = isFlagSet | isFlagClr;
    decodeHit = isEqSkip | isCmp | isRegClr | isRegSet | isIoClr | isIoSet | isBranch;
    // Immediate compare only reaches the upper sixteen registers
    regDAddr = isCmpImm ? {1'b1, instr[7:4]} : instr[8:4];
    regRAddr = {instr[9], instr[3:0]};
    ioAddr = instr[7:3];
    cmpOperand = isCmpImm ? {instr[11:8], instr[3:0]} : regR;
    regBit = regD[instr[2:0]];
    ioBit = ioByte[instr[2:0]];
    // Sign index uses N xor V directly, not the stored copy
    flagBit = (instr[2:0] == FLAG_S) ? (flagsIn[FLAG_N] ^ flagsIn[FLAG_V])
      : flagsIn[instr[2:0]];
    taken = isBranch & (isFlagSet ? flagBit : ~flagBit);
    skip = (isEqSkip & (regD == regR)) | (isRegClr & ~regBit) | (isRegSet & regBit)
      | (isIoClr & ~ioBit) | (isIoSet & ioBit);
    offset = {{9{instr[9]}}, instr[9:3]};
    if (taken)
    begin
      target = pc + offset + PC_STEP_NEXT;
      holds = 2'(CYC_BRANCH_TAKEN - 1);
    end
    else if (skip)
    begin
      target = pc + (nextIsTwoWord ? PC_SKIP_LONG : PC_SKIP_SHORT);
      holds = nextIsTwoWord ? 2'(CYC_SKIP_LONG - 1) : 2'(CYC_SKIP_SHORT - 1);
    end
    else
    begin
      target = pc + PC_STEP_NEXT;
      holds = 2'(CYC_PLAIN - 1);
    end
  end

  compare_flags u_cmp
  (
    .minuend(regD),
    .subtrahend(cmpOperand),
    .useCarry(isCmpCarry),
    .flagsIn(flagsIn),
    .flagsNew(cmpFlags)
  );

  // ****************************************
  // Sequencer
  // ****************************************
  seq_state_t state_q, state_d;
  logic pcLoad_q, pcLoad_d, flagWrite_q, flagWrite_d;
  logic [15:0] pcNext_q, pcNext_d;
  logic [7:0] flags_q, flags_d;

  assign instrReady = (state_q == ST_READY);
  assign accept = instrValid & instrReady & decodeHit;
  assign pcLoad = pcLoad_q;
  assign pcNext = pcNext_q;
  assign flagWrite = flagWrite_q;
  assign flagsOut = flags_q;

  always_comb
  begin
    state_d = state_q;
    pcLoad_d = 1'b0;
    flagWrite_d = 1'b0;
    pcNext_d = pcNext_q;
    flags_d = flags_q;
    case (state_q)
      ST_READY:
      begin
        if (accept)
        begin
          pcLoad_d = 1'b1;
          pcNext_d = target;
          // Branches and skips leave the flags alone
          flagWrite_d = isCmp;
          flags_d = isCmp ? cmpFlags : flags_q;
          case (holds)
            2'd1: state_d = ST_LAST;
            2'd2: state_d = ST_FIRST;
            default: state_d = ST_READY;
          endcase
        end
      end
      ST_FIRST: state_d = ST_LAST;
      ST_LAST: state_d = ST_READY;
      default: state_d = ST_READY;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_q <= ST_READY;
      pcLoad_q <= 1'b0;
      flagWrite_q <= 1'b0;
      pcNext_q <= RESET_PC_NEXT;
      flags_q <= RESET_FLAGS;
    end
    else
    begin
      state_q <= state_d;
      pcLoad_q <= pcLoad_d;
      flagWrite_q <= flagWrite_d;
      pcNext_q <= pcNext_d;
      flags_q <= flags_d;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence s_hold_one;
    ##1 !instrReady ##1 instrReady;
  endsequence

  sequence s_hold_two;
    ##1 !instrReady ##1 !instrReady ##1 instrReady;
  endsequence

  property p_eq_skip;
    accept && isEqSkip && (regD == regR) |=> pcLoad
      && (pcNext == $past(pc) + ($past(nextIsTwoWord) ? PC_SKIP_LONG : PC_SKIP_SHORT));
  endproperty
  a_eq_skip: assert property (p_eq_skip) else $error("equal skip target wrong");

  property p_eq_long;
    accept && isEqSkip && (regD == regR) && nextIsTwoWord |-> s_hold_two;
  endproperty
  a_eq_long: assert property (p_eq_long) else $error("long skip not three cycles");

  property p_cmp_result;
    accept && isCmp |=> flagWrite && (flagsOut == $past(cmpFlags)) && instrReady;
  endproperty
  a_cmp_result: assert property (p_cmp_result) else $error("compare flags wrong");

  property p_cmp_equal;
    accept && isCmpRegs && (regD == regR) |=> flagsOut[FLAG_Z] && !flagsOut[FLAG_C];
  endproperty
  a_cmp_equal: assert property (p_cmp_equal) else $error("equal compare flags wrong");

  property p_reg_skip;
    accept && isRegClr && !regBit && !nextIsTwoWord |=> pcNext == $past(pc) + PC_SKIP_SHORT;
  endproperty
  a_reg_skip: assert property (p_reg_skip) else $error("register skip wrong");

  property p_reg_noskip;
    accept && isRegSet && !regBit |=> (pcNext == $past(pc) + PC_STEP_NEXT) && instrReady;
  endproperty
  a_reg_noskip: assert property (p_reg_noskip) else $error("register no-skip wrong");

  property p_io_clear;
    accept && isIoClr && !ioBit |=>
      pcNext == $past(pc) + ($past(nextIsTwoWord) ? PC_SKIP_LONG : PC_SKIP_SHORT);
  endproperty
  a_io_clear: assert property (p_io_clear) else $error("io clear skip wrong");

  property p_io_set;
    accept && isIoSet && ioBit && !nextIsTwoWord |-> s_hold_one;
  endproperty
  a_io_set: assert property (p_io_set) else $error("io set skip timing wrong");

  property p_taken;
    accept && taken |=> (pcNext == $past(pc) + $past(offset) + PC_STEP_NEXT) && !flagWrite;
  endproperty
  a_taken: assert property (p_taken) else $error("taken branch wrong");

  property p_taken_time;
    accept && taken |-> s_hold_one;
  endproperty
  a_taken_time: assert property (p_taken_time) else $error("taken branch not two cycles");

  property p_not_taken;
    accept && isBranch && !taken |=> (pcNext == $past(pc) + PC_STEP_NEXT) && instrReady;
  endproperty
  a_not_taken: assert property (p_not_taken) else $error("untaken branch wrong");

  property p_zero_eq;
    accept && isFlagSet && (instr[2:0] == FLAG_Z) && flagsIn[FLAG_Z] |=> !instrReady;
  endproperty
  a_zero_eq: assert property (p_zero_eq) else $error("equal branch not taken");

  property p_signed_ge;
    accept && isFlagClr && (instr[2:0] == FLAG_S) && !(flagsIn[FLAG_N] ^ flagsIn[FLAG_V])
      |=> pcNext == $past(pc) + $past(offset) + PC_STEP_NEXT;
  endproperty
  a_signed_ge: assert property (p_signed_ge) else $error("signed ge not taken");

  property p_half;
    accept && isFlagClr && (instr[2:0] == FLAG_H) && flagsIn[FLAG_H] |=> instrReady;
  endproperty
  a_half: assert property (p_half) else $error("half-carry clear branch taken");

  property p_tbit;
    accept && isFlagSet && (instr[2:0] == FLAG_T) && flagsIn[FLAG_T] |-> s_hold_one;
  endproperty
  a_tbit: assert property (p_tbit) else $error("tbit set branch not taken");

  property p_ovf;
    accept && isFlagClr && (instr[2:0] == FLAG_V) && !flagsIn[FLAG_V] |=> !instrReady;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow clear branch not taken");

endmodule
`default_nettype wire

// file: sim/prog_model.sv
`timescale 1ns/1ps
`default_nettype none
module prog_model
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] flagsInit,
  input wire logic instrReady,
  input wire logic decodeHit,
  input wire logic pcLoad,
  input wire logic [15:0] pcNext,
  input wire logic flagWrite,
  input wire logic [7:0] flagsOut,
  output logic instrValid,
  output logic [15:0] instr,
  output logic [15:0] pc,
  output logic [7:0] flagsIn
);
  // ****************************************
  // Fetch, program counter and flag holder
  // ****************************************
  // The PC wraps onto a small store, so any branch target can be fetched
  logic [15:0] progMem [64];
  logic waitQ;

  assign instr = progMem[pc[5:0]];

  initial
  begin
    instrValid = 1'b0;
    pc = 16'h0000;
    flagsIn = 8'h00;
    waitQ = 1'b0;
  end

  always @(posedge mclk)
  begin
    if (rst)
    begin
      pc <= 16'h0000;
      flagsIn <= flagsInit;
      instrValid <= 1'b0;
      waitQ <= 1'b0;
    end
    else
    begin
      if (instrValid && instrReady)
      begin
        // Withdraw at once so a one-cycle op is not taken twice
        instrValid <= 1'b0;
        waitQ <= decodeHit;
        if (!decodeHit)
          pc <= pc + 16'h0001;
      end
      else if (waitQ && pcLoad)
      begin
        pc <= pcNext;
        waitQ <= 1'b0;
      end
      else if (!waitQ)
        instrValid <= 1'b1;
      if (flagWrite)
        flagsIn <= flagsOut;
    end
  end
endmodule
`default_nettype wire

// file: sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
  import branch_skip_pkg::*;
;
  logic mclk, rst, instrValid, nextIsTwoWord, instrReady, decodeHit, pcLoad, flagWrite;
  logic [15:0] instr, pc, pcNext, expPc, lfsr, w;
  logic [7:0] regD, regR, ioByte, flagsIn, flagsOut, flagsInit, expFlags;
  logic [4:0] regDAddr, regRAddr, ioAddr;
  logic expLoad, expFw;
  int fail_count, check_count, busy;
  logic [15:0] bases [10] = '{OPC_CMP_SKIP_EQ, OPC_CMP_REGS, OPC_CMP_CARRY, OPC_CMP_IMM,
    OPC_SKIP_REG_CLR, OPC_SKIP_REG_SET, OPC_SKIP_IO_CLR, OPC_SKIP_IO_SET,
    OPC_BRANCH_SET, OPC_BRANCH_CLR};
  logic [15:0] masks [10] = '{MASK_OP6, MASK_OP6, MASK_OP6, MASK_OP4, MASK_REGSKIP,
    MASK_REGSKIP, MASK_IOSKIP, MASK_IOSKIP, MASK_OP6, MASK_OP6};

  branch_compare_skip_unit DUT (.mclk(mclk), .rst(rst), .instrValid(instrValid),
    .instr(instr), .pc(pc), .nextIsTwoWord(nextIsTwoWord), .regD(regD), .regR(regR),
    .ioByte(ioByte), .flagsIn(flagsIn), .regDAddr(regDAddr), .regRAddr(regRAddr),
    .ioAddr(ioAddr), .decodeHit(decodeHit), .instrReady(instrReady), .pcLoad(pcLoad),
    .pcNext(pcNext), .flagWrite(flagWrite), .flagsOut(flagsOut));

  prog_model PM (.mclk(mclk), .rst(rst), .flagsInit(flagsInit), .instrReady(instrReady),
    .decodeHit(decodeHit), .pcLoad(pcLoad), .pcNext(pcNext), .flagWrite(flagWrite),
    .flagsOut(flagsOut), .instrValid(instrValid), .instr(instr), .pc(pc),
    .flagsIn(flagsIn));

  function automatic logic [15:0] next_rand();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (fail_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always #12.5 mclk = ~mclk;

  always @(posedge mclk)
  begin
    #2;
    {regD, regR} = next_rand();
    w = next_rand();
    ioByte = w[7:0];
    nextIsTwoWord = w[8];
    // Random bytes almost never match, so force equal operands half the time
    if (w[9])
      regR = regD;
  end

  // ****************************************
  // Reference model, judged mid-cycle
  // ****************************************
  always @(negedge mclk)
  begin : refModel
    logic [7:0] r, res;
    logic [4:0] dAddr;
    logic hit, skip, cin, fb;
    int cyc;
    if (!rst)
    begin
      chk(16'(instrReady), 16'(busy == 0));
      chk(16'(pcLoad), 16'(expLoad));
      chk(16'(flagWrite), 16'(expFw));
      if (expLoad)
        chk(pcNext, expPc);
      if (expFw)
        chk(16'(flagsOut & 8'hef), 16'(expFlags & 8'hef));
    end
    expLoad = 1'b0;
    expFw = 1'b0;
    if (rst)
      busy = 0;
    else if (busy > 0)
      busy--;
    else if (instrValid)
    begin
      expPc = pc + 16'h0001;
      skip = 1'b0;
      cyc = 1;
      hit = 1'b1;
      r = regR;
      cin = 1'b0;
      if ((instr & MASK_OP6) == OPC_CMP_SKIP_EQ)
        skip = (regD == regR);
      else if ((instr & MASK_OP4) == OPC_CMP_IMM)
      begin
        r = {instr[11:8], instr[3:0]};
        expFw = 1'b1;
      end
      else if ((instr & MASK_OP6) inside {OPC_CMP_REGS, OPC_CMP_CARRY})
      begin
        cin = ((instr & MASK_OP6) == OPC_CMP_CARRY) & flagsIn[0];
        expFw = 1'b1;
      end
      else if ((instr & MASK_REGSKIP) inside {OPC_SKIP_REG_CLR, OPC_SKIP_REG_SET})
        skip = (regD[instr[2:0]] == instr[9]);
      else if ((instr & MASK_IOSKIP) inside {OPC_SKIP_IO_CLR, OPC_SKIP_IO_SET})
        skip = (ioByte[instr[2:0]] == instr[9]);
      else if ((instr & MASK_OP6) inside {OPC_BRANCH_SET, OPC_BRANCH_CLR})
      begin
        fb = (instr[2:0] == FLAG_S) ? flagsIn[2] ^ flagsIn[3] : flagsIn[instr[2:0]];
        if (fb != instr[10])
        begin
          expPc = pc + {{9{instr[9]}}, instr[9:3]} + 16'h0001;
          cyc = 2;
        end
      end
      else
        hit = 1'b0;
      if (skip)
      begin
        expPc = pc + (nextIsTwoWord ? PC_SKIP_LONG : PC_SKIP_SHORT);
        cyc = nextIsTwoWord ? 3 : 2;
      end
      if (expFw)
      begin
        // The difference is never stored, only its flags
        res = regD - r - 8'(cin);
        expFlags = flagsIn;
        expFlags[0] = (~regD[7] & r[7]) | (r[7] & res[7]) | (res[7] & ~regD[7]);
        expFlags[1] = (res == 8'h00) & (((instr & MASK_OP6) != OPC_CMP_CARRY) | flagsIn[1]);
        expFlags[2] = res[7];
        expFlags[3] = (regD[7] & ~r[7] & ~res[7]) | (~regD[7] & r[7] & res[7]);
        expFlags[5] = (~regD[3] & r[3]) | (r[3] & res[3]) | (res[3] & ~regD[3]);
      end
      dAddr = ((instr & MASK_OP4) == OPC_CMP_IMM) ? {1'b1, instr[7:4]} : instr[8:4];
      chk(16'(decodeHit), 16'(hit));
      chk(16'(regDAddr), 16'(dAddr));
      chk(16'(regRAddr), 16'({instr[9], instr[3:0]}));
      chk(16'(ioAddr), 16'(instr[7:3]));
      expLoad = hit;
      busy = hit ? cyc - 1 : 0;
    end
  end

  initial
  begin
    mclk = 1'b0;
    rst = 1'b1;
    fail_count = 0;
    check_count = 0;
    busy = 0;
    expLoad = 1'b0;
    expFw = 1'b0;
    lfsr = 16'hecd0;
    {regD, regR} = 16'h0000;
    ioByte = 8'h00;
    nextIsTwoWord = 1'b0;
    w = next_rand();
    flagsInit = w[7:0];
    for (int i = 0; i < 64; i++)
    begin
      w = next_rand() % 16'h000b;
      if (w < 16'h000a)
        PM.progMem[i] = (next_rand() & ~masks[w]) | bases[w];
      else
        PM.progMem[i] = next_rand();
    end
    repeat (8) @(posedge mclk);
    #2;
    rst = 1'b0;
    @(negedge mclk);
    chk(pcNext, RESET_PC_NEXT);
    chk(16'(flagsOut), 16'(RESET_FLAGS));
    repeat (1500) @(posedge mclk);
    // Second reset with inverted flags, so both polarities of T and I are branched on
    #2;
    flagsInit = ~flagsInit;
    rst = 1'b1;
    repeat (2) @(posedge mclk);
    #2;
    rst = 1'b0;
    @(negedge mclk);
    chk(pcNext, RESET_PC_NEXT);
    chk(16'(flagsOut), 16'(RESET_FLAGS));
    chk(16'(instrReady), 16'h0001);
    repeat (1500) @(posedge mclk);
    end_of_test();
  end

  initial
  begin
    #(25 * 5000);
    fail_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
